// ===== src/lcd_segment_loader_i2c.sv
// Write-only two-wire slave loading segment registers of an LCD driver
// What this block does
// - Mode bit one selects duplex, frees address two
// - Duplex advances vector by one per byte
// - Duplex shows all eight registers, ignores bank
// - Direct shows even or odd bank by bit
// - Direct drive uses only the first backplane
// - Duplex pairs even with first, odd second
// - Register pair 2k,2k+1 drives segments 8k+1..8k+8
// - After reset master grounds first backplane, cascaded floats it
// - Reset grounds segments, clears registers and interface
// - Idle high; start and stop while clock high
// - One bit per clock; data stable clock high
// - Acknowledge address, control and matching data bytes by pulling data low
// - First byte is fixed write address only
// - All devices acknowledge the address together
// - Every device loads and acknowledges control byte
// - Only matching device stores and acknowledges data
// - Unlimited bytes, six-bit vector wraps around
// - Stop after control byte leaves registers unchanged
// - Vector top bits match subaddress; low bits pick register
// - Mode bit zero is direct, vector steps two
`timescale 1ns/1ps
module lcd_segment_loader_i2c (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        subaddress_line_0,
  input  wire logic        subaddress_line_1,
  input  wire logic        subaddr2_or_backplane2_pin_in,
  output logic             subaddr2_or_backplane2_pin_out,
  output logic             subaddr2_or_backplane2_pin_oe_n,
  input  wire logic        osc_master_strap,
  output logic             backplane_first_out,
  output logic             backplane_first_oe_n,
  output logic             backplane_second_used,
  output logic [31:0]      seg_plane_first,
  output logic [31:0]      seg_plane_second,
  output logic [7:0]       ctrl_byte
);

  typedef logic [7:0] seg_array_t [lcd_seg_pkg::SEG_REGS];

  lcd_seg_pkg::bus_lines_t bus_s;
  lcd_seg_pkg::bus_lines_t bus_prev_q;
  lcd_seg_pkg::rx_state_t  state_q;
  lcd_seg_pkg::ctrl_t      ctrl_q;
  logic [3:0]              bit_cnt_q;
  logic [7:0]              shift_q;
  logic                    ack_q;
  logic [7:0]              seg_q [lcd_seg_pkg::SEG_REGS];
  logic [3:0]              pins_s;
  logic                    master_q;
  logic                    strap_done_q;
  logic [3:0]              fill_q;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_det;
  logic                    stop_det;
  logic                    byte_done;
  logic                    ctrl_load;
  logic                    seg_load;
  logic                    sel_match;
  logic                    duplex;

  // Picks one bank as a 32-bit plane; bit 0 of a register is the lowest segment
  function automatic logic [31:0] plane(input seg_array_t r, input logic odd);
    logic [31:0] p;
    p = '0;
    for (int k = 0; k < lcd_seg_pkg::SEG_REGS / 2; k++) begin
      p[8*k +: 8] = r[2*k + int'(odd)];
    end
    return p;
  endfunction

  // Duplex drops the shared pin from the compare
  function automatic logic dev_match(input lcd_seg_pkg::ctrl_t c, input logic [2:0] sub);
    logic m;
    m = c.segment_byte_vector[4:3] == sub[1:0];
    if (c.drive_mode == lcd_seg_pkg::MODE_DIRECT) begin
      m = m && (c.segment_byte_vector[5] == sub[2]);
    end
    return m;
  endfunction

  pin_sync #(
    .W         (2),
    .RESET_VAL (8'h03)
  ) u_bus_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    ({scl_in, sda_in}),
    .level_out (bus_s)
  );

  pin_sync #(
    .W         (4),
    .RESET_VAL (8'h00)
  ) u_pin_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    ({osc_master_strap, subaddr2_or_backplane2_pin_in,
                 subaddress_line_1, subaddress_line_0}),
    .level_out (pins_s)
  );

  assign duplex    = ctrl_q.drive_mode == lcd_seg_pkg::MODE_DUPLEX;
  assign sel_match = dev_match(ctrl_q, pins_s[2:0]);
  assign scl_rise  = bus_s.scl && !bus_prev_q.scl;
  assign scl_fall  = !bus_s.scl && bus_prev_q.scl;
  // Data moving while clock is high is a bus condition, not a bit
  assign start_det = bus_s.scl && bus_prev_q.scl && bus_prev_q.sda && !bus_s.sda;
  assign stop_det  = bus_s.scl && bus_prev_q.scl && !bus_prev_q.sda && bus_s.sda;
  assign byte_done = bit_cnt_q == lcd_seg_pkg::BITS_PER_BYTE;
  assign ctrl_load = state_q == lcd_seg_pkg::ST_CTRL && scl_fall && byte_done;
  assign seg_load  = state_q == lcd_seg_pkg::ST_DATA && scl_fall && byte_done;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_prev_q <= 2'b11;
    end else begin
      bus_prev_q <= bus_s;
    end
  end

  // Strap caught once the synchroniser holds the pin, not its reset value
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fill_q       <= '0;
      master_q     <= 1'b0;
      strap_done_q <= 1'b0;
    end else begin
      fill_q <= {fill_q[2:0], 1'b1};
      if (fill_q[3] && !strap_done_q) begin
        master_q     <= !pins_s[3];
        strap_done_q <= 1'b1;
      end
    end
  end

  // Receive sequencer; start or stop override any state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q   <= lcd_seg_pkg::ST_IDLE;
      bit_cnt_q <= '0;
      shift_q   <= '0;
      ack_q     <= 1'b0;
    end else if (start_det) begin
      state_q   <= lcd_seg_pkg::ST_ADDR;
      bit_cnt_q <= '0;
      ack_q     <= 1'b0;
    end else if (stop_det) begin
      state_q   <= lcd_seg_pkg::ST_IDLE;
      bit_cnt_q <= '0;
      ack_q     <= 1'b0;
    end else begin
      unique case (state_q)
        lcd_seg_pkg::ST_IDLE: begin
          ack_q <= 1'b0;
        end
        lcd_seg_pkg::ST_ADDR, lcd_seg_pkg::ST_CTRL, lcd_seg_pkg::ST_DATA: begin
          if (scl_rise && !byte_done) begin
            shift_q   <= {shift_q[6:0], bus_s.sda};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall && byte_done) begin
            bit_cnt_q <= '0;
            if (state_q == lcd_seg_pkg::ST_ADDR) begin
              if (shift_q == lcd_seg_pkg::SLAVE_ADDR) begin
                state_q <= lcd_seg_pkg::ST_ACK_ADDR;
                ack_q   <= 1'b1;
              end else begin
                state_q <= lcd_seg_pkg::ST_IDLE;
              end
            end else if (state_q == lcd_seg_pkg::ST_CTRL) begin
              state_q <= lcd_seg_pkg::ST_ACK_CTRL;
              ack_q   <= 1'b1;
            end else begin
              state_q <= lcd_seg_pkg::ST_ACK_DATA;
              ack_q   <= sel_match;
            end
          end
        end
        lcd_seg_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            ack_q   <= 1'b0;
            state_q <= lcd_seg_pkg::ST_CTRL;
          end
        end
        lcd_seg_pkg::ST_ACK_CTRL, lcd_seg_pkg::ST_ACK_DATA: begin
          if (scl_fall) begin
            ack_q   <= 1'b0;
            state_q <= lcd_seg_pkg::ST_DATA;
          end
        end
      endcase
    end
  end

  // Every device keeps the same vector, selected or not
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q <= lcd_seg_pkg::CTRL_RESET;
    end else if (ctrl_load) begin
      ctrl_q <= shift_q;
    end else if (seg_load) begin
      // Six-bit add wraps modulo 64, so all ones steps to zero in duplex
      if (duplex) begin
        ctrl_q.segment_byte_vector <= ctrl_q.segment_byte_vector
                                      + lcd_seg_pkg::STEP_DUPLEX;
      end else begin
        ctrl_q.segment_byte_vector <= ctrl_q.segment_byte_vector
                                      + lcd_seg_pkg::STEP_DIRECT;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < lcd_seg_pkg::SEG_REGS; i++) begin
        seg_q[i] <= lcd_seg_pkg::SEG_RESET;
      end
    end else if (seg_load && sel_match) begin
      seg_q[ctrl_q.segment_byte_vector[2:0]] <= shift_q;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      seg_plane_first  <= '0;
      seg_plane_second <= '0;
    end else if (duplex) begin
      seg_plane_first  <= plane(seg_q, 1'b0);
      seg_plane_second <= plane(seg_q, 1'b1);
    end else begin
      seg_plane_first  <= plane(seg_q, ctrl_q.bank_select);
      seg_plane_second <= '0;
    end
  end

  // Cascaded parts take backplanes as sync inputs, so they float them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      backplane_first_oe_n            <= 1'b1;
      subaddr2_or_backplane2_pin_oe_n <= 1'b1;
      backplane_second_used           <= 1'b0;
    end else begin
      backplane_first_oe_n            <= !master_q;
      subaddr2_or_backplane2_pin_oe_n <= !(master_q && duplex);
      backplane_second_used           <= duplex;
    end
  end

  // Waveform generation lives outside this block; the level stays at ground
  assign backplane_first_out            = lcd_seg_pkg::BP_LEVEL_VSS;
  assign subaddr2_or_backplane2_pin_out = lcd_seg_pkg::BP_LEVEL_VSS;
  assign sda_out                        = lcd_seg_pkg::SDA_LOW;
  assign sda_oe_n                       = !ack_q;
  assign ctrl_byte                      = ctrl_q;

  a_addr_ack: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q == lcd_seg_pkg::ST_ADDR && scl_fall && byte_done && !start_det && !stop_det
     && shift_q == lcd_seg_pkg::SLAVE_ADDR) |=> (!sda_oe_n && state_q == lcd_seg_pkg::ST_ACK_ADDR))
    else $error("address byte not acknowledged");

  a_addr_reject: assert property (@(posedge clk_sys) disable iff (reset)
    (state_q == lcd_seg_pkg::ST_ADDR && scl_fall && byte_done && !start_det && !stop_det
     && shift_q != lcd_seg_pkg::SLAVE_ADDR) |=> (sda_oe_n && state_q == lcd_seg_pkg::ST_IDLE))
    else $error("foreign address acknowledged");

  a_ctrl_load: assert property (@(posedge clk_sys) disable iff (reset)
    (ctrl_load && !start_det && !stop_det) |=> (ctrl_q == $past(shift_q) && !sda_oe_n))
    else $error("control byte not taken or not acknowledged");

  a_data_silent: assert property (@(posedge clk_sys) disable iff (reset)
    (seg_load && !sel_match && !start_det && !stop_det) |=> sda_oe_n [*1] ##0
      $stable({seg_q[0], seg_q[1], seg_q[2], seg_q[3], seg_q[4], seg_q[5], seg_q[6], seg_q[7]}))
    else $error("unselected device answered data byte");

  a_step_duplex: assert property (@(posedge clk_sys) disable iff (reset)
    (seg_load && duplex) |=> ctrl_q.segment_byte_vector
      == 6'($past(ctrl_q.segment_byte_vector) + lcd_seg_pkg::STEP_DUPLEX))
    else $error("duplex vector did not step by one");

  a_step_direct: assert property (@(posedge clk_sys) disable iff (reset)
    (seg_load && !duplex) |=> ctrl_q.segment_byte_vector
      == 6'($past(ctrl_q.segment_byte_vector) + lcd_seg_pkg::STEP_DIRECT))
    else $error("direct vector did not step by two");

  a_bank_view: assert property (@(posedge clk_sys) disable iff (reset)
    (!duplex && !ctrl_q.bank_select) |=> (seg_plane_first[7:0] == $past(seg_q[0])
      && seg_plane_first[31:24] == $past(seg_q[6]) && seg_plane_second == '0))
    else $error("direct bank zero does not show even registers");

  a_duplex_view: assert property (@(posedge clk_sys) disable iff (reset)
    duplex |=> (seg_plane_second[15:8] == $past(seg_q[3])
      && seg_plane_first[23:16] == $past(seg_q[4])))
    else $error("duplex planes misrouted");

  a_cascade_float: assert property (@(posedge clk_sys) disable iff (reset)
    (strap_done_q && !master_q) |=> ##1 (backplane_first_oe_n && subaddr2_or_backplane2_pin_oe_n))
    else $error("cascaded device drives a backplane");

  a_start_seen: assert property (@(posedge clk_sys) disable iff (reset)
    start_det |=> (state_q == lcd_seg_pkg::ST_ADDR && bit_cnt_q == 4'h0 && sda_oe_n))
    else $error("start condition not taken");

  a_reset_clear: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(reset) |-> (seg_plane_first == '0 && ctrl_q == lcd_seg_pkg::CTRL_RESET))
    else $error("state not cleared by reset");

endmodule

// ===== src/lcd_seg_pkg.sv
// Shared constants and types for the LCD segment loader
package lcd_seg_pkg;

  localparam int          SEG_REGS      = 8;
  localparam int          SEG_OUTS      = 32;
  localparam int          VEC_W         = 6;
  localparam logic [7:0]  SLAVE_ADDR    = 8'h74;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [5:0]  STEP_DIRECT   = 6'h02;
  localparam logic [5:0]  STEP_DUPLEX   = 6'h01;
  localparam logic        MODE_DIRECT   = 1'b0;
  localparam logic        MODE_DUPLEX   = 1'b1;
  localparam logic [7:0]  SEG_RESET     = 8'h00;
  localparam logic        BP_LEVEL_VSS  = 1'b0;
  localparam logic        SDA_LOW       = 1'b0;

  // Control byte: mode in bit 7, bank in bit 6, vector below
  typedef struct packed {
    logic       drive_mode;
    logic       bank_select;
    logic [5:0] segment_byte_vector;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 8'h00;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_t;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ACK_ADDR = 7'h04,
    ST_CTRL     = 7'h08,
    ST_ACK_CTRL = 7'h10,
    ST_DATA     = 7'h20,
    ST_ACK_DATA = 7'h40
  } rx_state_t;

endpackage

// ===== src/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W         = 1,
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_q <= RESET_VAL[W-1:0];
      s2_q <= RESET_VAL[W-1:0];
      s3_q <= RESET_VAL[W-1:0];
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      level_out <= RESET_VAL[W-1:0];
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ===== tb/i2c_master_model.sv
// Behavioural two-wire bus master that writes bytes to the segment loader
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic clk_sys,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Phases of eight system clocks leave margin over the five-clock minimum
  task automatic start_cond();
    sda = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda = 1'b0;
    tick(8);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    sda = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda = 1'b1;
    tick(8);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      tick(4);
      sda = b[i];
      tick(4);
      scl = 1'b1;
      tick(8);
      scl = 1'b0;
    end
    tick(4);
    sda = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    ack = ~sda_wire;
    tick(4);
    scl = 1'b0;
  endtask
endmodule

// ===== tb/tb_lcd_segment_loader_i2c.sv
// Self-checking bench for the segment loader, driven by the bus master model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_lcd_segment_loader_i2c;
  logic        clk_sys, reset, strap, a0, a1, a2_drv, m_scl, m_sda, ack;
  logic        sda_out, sda_oe_n, a2_out, a2_oe_n, bp1_out, bp1_oe_n, second_used;
  logic [31:0] plane_first, plane_second;
  logic [7:0]  ctrl_byte;
  logic [7:0]  regs [8];
  int          seed = 85882;
  int          error_cnt = 0;
  int          cmp_count = 0;
  // Pull-up on the data line, open drain on both sides
  wire sda_wire = m_sda & (sda_oe_n | sda_out);
  wire a2_wire  = a2_oe_n ? a2_drv : a2_out;

  i2c_master_model i2c_master_model_i (.clk_sys(clk_sys), .sda_wire(sda_wire),
    .scl(m_scl), .sda(m_sda));

  lcd_segment_loader_i2c lcd_segment_loader_i2c_i (
    .clk_sys(clk_sys), .reset(reset), .scl_in(m_scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .subaddress_line_0(a0),
    .subaddress_line_1(a1), .subaddr2_or_backplane2_pin_in(a2_wire),
    .subaddr2_or_backplane2_pin_out(a2_out), .subaddr2_or_backplane2_pin_oe_n(a2_oe_n),
    .osc_master_strap(strap), .backplane_first_out(bp1_out),
    .backplane_first_oe_n(bp1_oe_n), .backplane_second_used(second_used),
    .seg_plane_first(plane_first), .seg_plane_second(plane_second),
    .ctrl_byte(ctrl_byte));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [63:0] planes(input logic [7:0] cb);
    logic [31:0] f;
    logic [31:0] s;
    for (int k = 0; k < 4; k++) begin
      f[8*k +: 8] = cb[7] ? regs[2*k] : regs[2*k + int'(cb[6])];
      s[8*k +: 8] = cb[7] ? regs[2*k + 1] : 8'h00;
    end
    return {s, f};
  endfunction

  task automatic do_reset(input logic strap_val);
    strap = strap_val;
    reset = 1'b1;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    repeat (10) @(negedge clk_sys);
    foreach (regs[i]) regs[i] = 8'h00;
    `CHK("bp1_oe_n", strap_val, bp1_oe_n)
    `CHK("bp1_out", 1'b0, bp1_out)
    `CHK("ctrl", 8'h00, ctrl_byte)
    `CHK("planes", 64'h0000_0000_0000_0000, {plane_second, plane_first})
    `CHK("sda_oe_n", 1'b1, sda_oe_n)
  endtask

  // One write transfer: address, control byte, n random data bytes, stop
  task automatic xfer(input logic [7:0] cb, input int n);
    logic [5:0] v;
    logic [7:0] b;
    logic       hit;
    v = cb[5:0];
    i2c_master_model_i.start_cond();
    i2c_master_model_i.send_byte(lcd_seg_pkg::SLAVE_ADDR, ack);
    `CHK("addr_ack", 1'b1, ack)
    i2c_master_model_i.send_byte(cb, ack);
    `CHK("ctrl_ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      hit = cb[7] ? (v[4:3] == {a1, a0}) : (v[5:3] == {a2_drv, a1, a0});
      i2c_master_model_i.send_byte(b, ack);
      `CHK("data_ack", hit, ack)
      if (hit) regs[v[2:0]] = b;
      v = v + (cb[7] ? 6'h01 : 6'h02);
    end
    i2c_master_model_i.stop_cond();
    repeat (10) @(negedge clk_sys);
    `CHK("ctrl", {cb[7:6], v}, ctrl_byte)
    `CHK("planes", planes(cb), {plane_second, plane_first})
    `CHK("second_used", cb[7], second_used)
    `CHK("a2_oe_n", ~cb[7], a2_oe_n)
  endtask

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    {a0, a1, a2_drv} = 3'($random(seed));
    do_reset(1'b0);
    for (int i = 0; i < 8; i++) begin
      i2c_master_model_i.start_cond();
      i2c_master_model_i.send_byte(i == 0 ? 8'h75 : 8'h74 ^ (8'h01 << i), ack);
      `CHK("bad_addr_ack", 1'b0, ack)
      i2c_master_model_i.stop_cond();
    end
    xfer({2'b00, a2_drv, a1, a0, 3'b000}, 4);
    xfer({2'b00, a2_drv, a1, a0, 3'b001}, 4);
    xfer({2'b01, a2_drv, a1, a0, 3'b000}, 0);
    xfer({2'b00, ~a2_drv, a1, a0, 3'b010}, 2);
    // In duplex the top vector bit must not matter
    xfer({1'b1, 1'($random(seed)), ~a2_drv, a1, a0, 3'b000}, 8);
    xfer({2'b10, 6'h3f}, 3);
    for (int t = 0; t < 8; t++) begin
      {a0, a1, a2_drv} = 3'($random(seed));
      repeat (10) @(negedge clk_sys);
      xfer(8'($random(seed)), int'($unsigned($random(seed)) % 6));
    end
    do_reset(1'b1);
    give_verdict();
  end
endmodule
